// *** hdl/bdp_regs.sv ***
// Device-specific diagnostic, arbiter and read prefetch configuration registers of the bridge.
//
// How it works
// - Writing one to reset bit starts chip reset.
// - Chip reset restores buffers, registers, both interfaces; this bank reloads only its own registers and drives CHIP_RESET.
// - Reset bit clears itself when reset finishes.
// - Reset bit asserts secondary reset and bridge bit.
// - Secondary reset holds until bridge bit cleared.
// - Test field selects exercised counter bytes.
// - Arbiter bits put each master in priority group.
// - Arbiter resets with only bridge high priority.
// - Downstream prefetch code selects 16 to 64 dwords.
// - Upstream prefetch code selects 16 to 64 dwords.
// - Downstream line mode prefetches to line boundary.
// - Downstream count mode uses downstream prefetch field.
// - Upstream line mode prefetches to line boundary.
// - Upstream count mode uses upstream prefetch field.
// - Flush discards read completions on posted write.
// - Without flush, standard bridge ordering is kept.
// - Reserved bits ignore writes, read zero.
`timescale 1ns/1ps
`include "bdp_params.svh"

module bdp_regs
#(
    parameter logic [15:0] CHIP_RST_CYCLES = `BDP_CHIP_RST_CYCLES
)
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    input  wire logic        CFG_WR,
    input  wire logic        CFG_RD,
    input  wire logic [7:0]  CFG_ADDR,
    input  wire logic [3:0]  PRIMARY_COMMAND_BYTE_ENABLES_N,
    input  wire logic [31:0] CFG_WDATA,
    input  wire logic        BRIDGE_SEC_RESET_BIT,
    input  wire logic [7:0]  CACHE_LINE_SIZE,
    input  wire logic        PRI_POSTED_WRITE,
    output logic      [31:0] CFG_RDATA,
    output logic             CFG_ACK,
    output logic             CHIP_RESET,
    output logic             SEC_BUS_RESET,
    output logic             BRIDGE_SEC_RESET_SET,
    output logic      [1:0]  CNT_TEST_MODE,
    output logic      [2:0]  CNT_BYTE_EXERCISE,
    output logic      [9:0]  ARB_HIGH_PRIO,
    output logic      [7:0]  DS_PREFETCH_DW,
    output logic      [7:0]  US_PREFETCH_DW,
    output logic             NP_FLUSH_EN,
    output logic             NP_FLUSH_PULSE
);

    bdp_pkg::bdp_main_t st_reg;
    bdp_pkg::bdp_main_t st_next;

    logic             seq_busy;
    logic             seq_done;
    logic             hit_diag;
    logic             hit_rdctl;
    logic             wr_ok;
    logic      [3:0]  lane_en;
    logic      [7:0]  rdctl_byte;

    // Cycles from the rise of the reset bit to the done pulse of the timer.
    localparam int CHIP_RUN = int'(CHIP_RST_CYCLES) + 1;

    // Initial state of every register, used at power-on and at the end of a chip reset.
    localparam bdp_pkg::bdp_main_t RST_STATE = '{
        chip_bit:    1'b0,
        test_mode:   `BDP_TEST_RESET,
        byte_ex:     3'h7,
        arb:         `BDP_ARB_RESET,
        ds_max:      2'h0,
        us_max:      2'h0,
        ds_line:     1'b1,
        us_line:     1'b1,
        flush:       1'b0,
        sec_rst:     1'b0,
        sec_set:     1'b0,
        flush_pulse: 1'b0,
        rdata:       32'h0000_0000,
        ack:         1'b0
    };

    // Address decode; lanes are active when their byte enable is driven low.
    assign hit_diag  = ({CFG_ADDR[7:2], 2'b00} == `BDP_OFS_DIAG_ARB);
    assign hit_rdctl = ({CFG_ADDR[7:2], 2'b00} == `BDP_OFS_READ_CTL);
    assign lane_en   = ~PRIMARY_COMMAND_BYTE_ENABLES_N;
    assign wr_ok     = CFG_WR & ~st_reg.chip_bit;

    // Read transaction control byte as software sees it; bit 3 is reserved.
    assign rdctl_byte = {st_reg.ds_max, st_reg.us_max, 1'b0, st_reg.ds_line, st_reg.us_line, st_reg.flush};

    // Timer that holds the chip reset for a fixed time.
    bdp_reset_seq
    #(
        .CYCLES (CHIP_RST_CYCLES)
    )
    u_seq
    (
        .clk    (CLK_SYS),
        .rst    (RESET),
        .start  (st_reg.chip_bit),
        .busy   (seq_busy),
        .done   (seq_done)
    );

    // Downstream prefetch limit.
    bdp_prefetch_limit u_ds_pf
    (
        .clk        (CLK_SYS),
        .rst        (RESET),
        .line_en    (st_reg.ds_line),
        .max_code   (st_reg.ds_max),
        .line_size  (CACHE_LINE_SIZE),
        .limit_dw   (DS_PREFETCH_DW)
    );

    // Upstream prefetch limit.
    bdp_prefetch_limit u_us_pf
    (
        .clk        (CLK_SYS),
        .rst        (RESET),
        .line_en    (st_reg.us_line),
        .max_code   (st_reg.us_max),
        .line_size  (CACHE_LINE_SIZE),
        .limit_dw   (US_PREFETCH_DW)
    );

    // Register writes, chip reset handling, derived outputs and read answers.
    always_comb
    begin
        st_next = st_reg;
        if (seq_done)
        begin
            st_next = RST_STATE;
        end
        else if (wr_ok && hit_diag)
        begin
            if (lane_en[1])
            begin
                if (CFG_WDATA[`BDP_CHIP_RST_BIT])
                begin
                    st_next.chip_bit = 1'b1;
                end
                st_next.test_mode = CFG_WDATA[`BDP_TEST_LSB +: 2];
            end
            if (lane_en[2])
            begin
                st_next.arb[7:0] = CFG_WDATA[`BDP_ARB_LSB +: 8];
            end
            if (lane_en[3])
            begin
                st_next.arb[9:8] = CFG_WDATA[`BDP_ARB_MSB -: 2];
            end
        end
        else if (wr_ok && hit_rdctl && lane_en[0])
        begin
            st_next.ds_max  = CFG_WDATA[`BDP_DS_MAX_LSB +: 2];
            st_next.us_max  = CFG_WDATA[`BDP_US_MAX_LSB +: 2];
            st_next.ds_line = CFG_WDATA[`BDP_DS_LINE_BIT];
            st_next.us_line = CFG_WDATA[`BDP_US_LINE_BIT];
            st_next.flush   = CFG_WDATA[`BDP_FLUSH_BIT];
        end

        // Counter byte select: bit 0 is byte 0, bit 1 byte 1, bit 2 byte 2.
        case (st_next.test_mode)
            2'b00:   st_next.byte_ex = 3'h7;
            2'b01:   st_next.byte_ex = 3'h2;
            2'b10:   st_next.byte_ex = 3'h4;
            2'b11:   st_next.byte_ex = 3'h1;
            default: st_next.byte_ex = 3'h7;
        endcase

        // Secondary reset follows the reset bit and then the bridge control bit.
        st_next.sec_set = st_next.chip_bit;
        st_next.sec_rst = st_next.chip_bit | BRIDGE_SEC_RESET_BIT;

        // Flush request only while the flush control is set.
        st_next.flush_pulse = PRI_POSTED_WRITE & st_reg.flush;

        // Read answer one cycle after the request; reserved bits read zero.
        st_next.ack   = CFG_RD | CFG_WR;
        st_next.rdata = 32'h0000_0000;
        if (CFG_RD && hit_diag)
        begin
            st_next.rdata = {6'h00, st_reg.arb, 5'h00, st_reg.test_mode, st_reg.chip_bit, 8'h00};
        end
        else if (CFG_RD && hit_rdctl)
        begin
            st_next.rdata = {24'h00_0000, rdctl_byte};
        end
    end

    // State register.
    always_ff @(posedge CLK_SYS or posedge RESET)
    begin
        if (RESET)
        begin
            st_reg <= RST_STATE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register.
    assign CFG_RDATA            = st_reg.rdata;
    assign CFG_ACK              = st_reg.ack;
    assign CHIP_RESET           = st_reg.chip_bit;
    assign SEC_BUS_RESET        = st_reg.sec_rst;
    assign BRIDGE_SEC_RESET_SET = st_reg.sec_set;
    assign CNT_TEST_MODE        = st_reg.test_mode;
    assign CNT_BYTE_EXERCISE    = st_reg.byte_ex;
    assign ARB_HIGH_PRIO        = st_reg.arb;
    assign NP_FLUSH_EN          = st_reg.flush;
    assign NP_FLUSH_PULSE       = st_reg.flush_pulse;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    // Accepted write with lane 1 enabled and the reset bit set.
    sequence s_chip_req;
        wr_ok && hit_diag && lane_en[1] && CFG_WDATA[8];
    endsequence

    // Accepted write with lane 1 enabled and the reset bit clear while idle.
    sequence s_chip_zero;
        wr_ok && hit_diag && lane_en[1] && !CFG_WDATA[8] && !seq_done;
    endsequence

    // Whole chip reset: the bit rises, then the timer finishes a fixed time later.
    sequence s_chip_run;
        $rose(CHIP_RESET) ##CHIP_RUN seq_done;
    endsequence

    property p_chip_start;
        s_chip_req |=> CHIP_RESET;
    endproperty
    a_chip_start: assert property (p_chip_start) else $error("Reset bit write did not start chip reset.");

    property p_chip_zero;
        s_chip_zero ##0 !CHIP_RESET |=> !CHIP_RESET;
    endproperty
    a_chip_zero: assert property (p_chip_zero) else $error("Writing zero started chip reset.");

    property p_chip_length;
        $rose(CHIP_RESET) |-> ##CHIP_RUN seq_done;
    endproperty
    a_chip_length: assert property (p_chip_length) else $error("Chip reset length wrong.");

    property p_chip_hold;
        CHIP_RESET && !seq_done |=> CHIP_RESET && (seq_busy || seq_done);
    endproperty
    a_chip_hold: assert property (p_chip_hold) else $error("Chip reset dropped before its timer ended.");

    property p_self_clear;
        s_chip_run |=> !CHIP_RESET;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("Reset bit did not clear itself.");

    property p_restore;
        seq_done |=> ARB_HIGH_PRIO == 10'h200 && CNT_TEST_MODE == 2'b00 && !NP_FLUSH_EN
                     && st_reg.ds_line && st_reg.us_line && st_reg.ds_max == 2'b00;
    endproperty
    a_restore: assert property (p_restore) else $error("Registers not restored by chip reset.");

    property p_sec_assert;
        CHIP_RESET |-> SEC_BUS_RESET && BRIDGE_SEC_RESET_SET;
    endproperty
    a_sec_assert: assert property (p_sec_assert) else $error("Secondary reset not asserted with reset bit.");

    property p_sec_set;
        BRIDGE_SEC_RESET_SET == CHIP_RESET;
    endproperty
    a_sec_set: assert property (p_sec_set) else $error("Bridge bit request does not follow reset bit.");

    property p_sec_hold;
        !st_next.chip_bit && BRIDGE_SEC_RESET_BIT |=> SEC_BUS_RESET;
    endproperty
    a_sec_hold: assert property (p_sec_hold) else $error("Secondary reset dropped before bit cleared.");

    property p_sec_release;
        !st_next.chip_bit && !BRIDGE_SEC_RESET_BIT |=> !SEC_BUS_RESET;
    endproperty
    a_sec_release: assert property (p_sec_release) else $error("Secondary reset not released.");

    property p_test_decode;
        (CNT_TEST_MODE == 2'b11 -> CNT_BYTE_EXERCISE == 3'h1) &&
        (CNT_TEST_MODE == 2'b01 -> CNT_BYTE_EXERCISE == 3'h2) &&
        (CNT_TEST_MODE == 2'b10 -> CNT_BYTE_EXERCISE == 3'h4) &&
        (CNT_TEST_MODE == 2'b00 -> CNT_BYTE_EXERCISE == 3'h7);
    endproperty
    a_test_decode: assert property (p_test_decode) else $error("Counter byte select decode wrong.");

    property p_arb_write;
        wr_ok && hit_diag && lane_en[2] && !seq_done |=> ARB_HIGH_PRIO[7:0] == $past(CFG_WDATA[23:16]);
    endproperty
    a_arb_write: assert property (p_arb_write) else $error("Arbiter low byte not written.");

    property p_arb_high;
        wr_ok && hit_diag && lane_en[3] && !seq_done |=> ARB_HIGH_PRIO[9:8] == $past(CFG_WDATA[25:24]);
    endproperty
    a_arb_high: assert property (p_arb_high) else $error("Arbiter high bits not written.");

    property p_arb_keep;
        CFG_WR && hit_diag && !lane_en[3] && !seq_done |=> $stable(ARB_HIGH_PRIO[9:8]);
    endproperty
    a_arb_keep: assert property (p_arb_keep) else $error("Disabled lane changed arbiter bits.");

    property p_reserved;
        CFG_RD && hit_diag |=> CFG_ACK && CFG_RDATA[31:26] == 6'h00 && CFG_RDATA[15:11] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits read nonzero.");

    property p_rdctl_zero;
        CFG_RD && hit_rdctl |=> CFG_ACK && CFG_RDATA[31:8] == 24'h00_0000 && !CFG_RDATA[3];
    endproperty
    a_rdctl_zero: assert property (p_rdctl_zero) else $error("Reserved read control bits nonzero.");

    property p_write_refused;
        CFG_WR && CHIP_RESET && !seq_done
        |=> $stable(ARB_HIGH_PRIO) && $stable(CNT_TEST_MODE) && $stable(NP_FLUSH_EN);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("Write landed during chip reset.");

    property p_flush_on;
        PRI_POSTED_WRITE && NP_FLUSH_EN |=> NP_FLUSH_PULSE;
    endproperty
    a_flush_on: assert property (p_flush_on) else $error("Posted write did not flush completions.");

    property p_flush_off;
        !NP_FLUSH_EN |=> !NP_FLUSH_PULSE;
    endproperty
    a_flush_off: assert property (p_flush_off) else $error("Flush issued with flush control clear.");

    property p_flush_write;
        wr_ok && hit_rdctl && lane_en[0] && !seq_done |=> NP_FLUSH_EN == $past(CFG_WDATA[0]);
    endproperty
    a_flush_write: assert property (p_flush_write) else $error("Flush control not written.");

    property p_flush_cause;
        NP_FLUSH_PULSE |-> $past(PRI_POSTED_WRITE) && $past(NP_FLUSH_EN);
    endproperty
    a_flush_cause: assert property (p_flush_cause) else $error("Flush without posted write.");

endmodule

// *** hdl/bdp_params.svh ***
// Offsets, field positions, reset values and counts of the bridge diagnostic register bank.
`ifndef BDP_PARAMS_SVH
`define BDP_PARAMS_SVH

// Dword byte addresses of the two register words.
`define BDP_OFS_DIAG_ARB     8'h40
`define BDP_OFS_READ_CTL     8'h44

// Field positions in the dword at the diagnostic and arbiter offset.
`define BDP_CHIP_RST_BIT     8
`define BDP_TEST_LSB         9
`define BDP_ARB_LSB          16
`define BDP_ARB_MSB          25

// Field positions in the read transaction control byte.
`define BDP_DS_MAX_LSB       6
`define BDP_US_MAX_LSB       4
`define BDP_DS_LINE_BIT      2
`define BDP_US_LINE_BIT      1
`define BDP_FLUSH_BIT        0

// Reset values.
`define BDP_TEST_RESET       2'h0
`define BDP_ARB_RESET        10'h200
`define BDP_RDCTL_RESET      8'h06

// Prefetch step per code and the fallback line length, both in dwords.
`define BDP_PF_STEP_DW       8'h10
`define BDP_PF_LINE_DEF_DW   8'h10

// Clock cycles that the chip reset timer runs; the reset bit stays set two cycles longer.
`define BDP_CHIP_RST_CYCLES  16'h0010

`endif

// *** hdl/bdp_pkg.sv ***
// Types shared by the bridge diagnostic register bank modules.
package bdp_pkg;

    // States of the chip reset sequencer.
    typedef enum logic [1:0]
    {
        BDP_SEQ_IDLE = 2'b00,
        BDP_SEQ_RUN  = 2'b01,
        BDP_SEQ_DONE = 2'b10
    } bdp_seq_state_t;

    // State of the chip reset sequencer.
    typedef struct packed
    {
        bdp_seq_state_t state;
        logic [15:0]    count;
        logic           busy;
        logic           done;
    } bdp_seq_t;

    // State of one prefetch limit calculator.
    typedef struct packed
    {
        logic [7:0] limit;
    } bdp_pf_t;

    // State of the register bank.
    typedef struct packed
    {
        logic        chip_bit;
        logic [1:0]  test_mode;
        logic [2:0]  byte_ex;
        logic [9:0]  arb;
        logic [1:0]  ds_max;
        logic [1:0]  us_max;
        logic        ds_line;
        logic        us_line;
        logic        flush;
        logic        sec_rst;
        logic        sec_set;
        logic        flush_pulse;
        logic [31:0] rdata;
        logic        ack;
    } bdp_main_t;

endpackage

// *** hdl/bdp_reset_seq.sv ***
// Timer that runs the internal chip reset for a fixed number of cycles.
`timescale 1ns/1ps
`include "bdp_params.svh"

module bdp_reset_seq
#(
    parameter logic [15:0] CYCLES = `BDP_CHIP_RST_CYCLES
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    bdp_pkg::bdp_seq_t st_reg;
    bdp_pkg::bdp_seq_t st_next;

    // Idle until started, count out the reset, pulse done once, then idle again.
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        case (st_reg.state)
            bdp_pkg::BDP_SEQ_IDLE:
            begin
                if (start)
                begin
                    st_next.state = bdp_pkg::BDP_SEQ_RUN;
                    st_next.count = 16'h0000;
                    st_next.busy  = 1'b1;
                end
            end
            bdp_pkg::BDP_SEQ_RUN:
            begin
                if (st_reg.count >= CYCLES - 16'h0001)
                begin
                    st_next.state = bdp_pkg::BDP_SEQ_DONE;
                    st_next.busy  = 1'b0;
                    st_next.done  = 1'b1;
                end
                else
                begin
                    st_next.count = st_reg.count + 16'h0001;
                end
            end
            bdp_pkg::BDP_SEQ_DONE:
            begin
                st_next.state = bdp_pkg::BDP_SEQ_IDLE;
            end
            default:
            begin
                st_next.state = bdp_pkg::BDP_SEQ_IDLE;
                st_next.busy  = 1'b0;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '{state: bdp_pkg::BDP_SEQ_IDLE, count: 16'h0000, busy: 1'b0, done: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;

endmodule

// *** hdl/bdp_prefetch_limit.sv ***
// Prefetch length limit for one direction of memory read forwarding.
`timescale 1ns/1ps
`include "bdp_params.svh"

module bdp_prefetch_limit
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       line_en,
    input  wire logic [1:0] max_code,
    input  wire logic [7:0] line_size,
    output logic      [7:0] limit_dw
);

    bdp_pkg::bdp_pf_t st_reg;
    bdp_pkg::bdp_pf_t st_next;

    // Line mode follows the cache line size, or 16 dwords when it is zero, else the coded count applies.
    always_comb
    begin
        st_next = st_reg;
        if (line_en)
        begin
            st_next.limit = (line_size == 8'h00) ? `BDP_PF_LINE_DEF_DW : line_size;
        end
        else
        begin
            st_next.limit = 8'((max_code + 8'h01) * `BDP_PF_STEP_DW);
        end
    end

    // State register.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= '{limit: `BDP_PF_LINE_DEF_DW};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign limit_dw = st_reg.limit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_line_default;
        line_en && line_size == 8'h00 |=> limit_dw == 8'h10;
    endproperty
    a_line_default: assert property (p_line_default) else $error("Default line prefetch not 16 dwords.");

    property p_line_size;
        line_en && line_size != 8'h00 |=> limit_dw == $past(line_size);
    endproperty
    a_line_size: assert property (p_line_size) else $error("Line prefetch ignores line size.");

    property p_code_count;
        !line_en |=> limit_dw == 8'((($past(max_code)) + 8'h01) * 8'h10);
    endproperty
    a_code_count: assert property (p_code_count) else $error("Coded prefetch count wrong.");

    property p_code_max;
        !line_en && max_code == 2'b11 |=> limit_dw == 8'h40;
    endproperty
    a_code_max: assert property (p_code_max) else $error("Code 11 not 64 dwords.");

endmodule

// *** testbench/bdp_host_model.sv ***
// Host model that issues configuration reads and writes to the register bank.
`timescale 1ns/1ps

module bdp_host_model
(
    input  wire logic        clk,
    output logic             cfg_wr,
    output logic             cfg_rd,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       be_n,
    output logic [31:0]      wdata,
    input  wire logic [31:0] rdata,
    input  wire logic        ack
);
    // Idle bus levels at time zero.
    initial
    begin
        cfg_wr   = 1'b0;
        cfg_rd   = 1'b0;
        cfg_addr = 8'hFF;
        be_n     = 4'hF;
        wdata    = 32'h0;
    end

    // One strobe cycle; released address and data lines show the inverse so stale values never pass.
    task automatic cycle(input logic wr, input logic [7:0] a, input logic [3:0] b,
                         input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        cfg_wr   = wr;
        cfg_rd   = ~wr;
        cfg_addr = a;
        be_n     = b;
        wdata    = d;
        @(posedge clk);
        @(negedge clk);
        q        = (ack === 1'b1) ? rdata : 32'hXXXXXXXX;
        cfg_wr   = 1'b0;
        cfg_rd   = 1'b0;
        cfg_addr = ~a;
        be_n     = 4'hF;
        wdata    = ~d;
    endtask

    // Write with the given active-low lane enables.
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
        logic [31:0] q;
        cycle(1'b1, a, b, d, q);
    endtask

    // Read of a full dword.
    task automatic cfg_read(input logic [7:0] a, output logic [31:0] q);
        cycle(1'b0, a, 4'h0, 32'h0, q);
    endtask
endmodule

// *** testbench/test_bdp_regs.sv ***
// Self-checking bench for the bridge diagnostic register bank.
`timescale 1ns/1ps

module test_bdp_regs;
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic        sec_bit = 1'b0;
    logic [7:0]  cls     = 8'h00;
    logic        pw      = 1'b0;
    logic        cfg_wr, cfg_rd, ack, chip_rst, sec_rst, sec_set, fl_en, fl_pulse;
    logic [7:0]  addr, ds_dw, us_dw;
    logic [3:0]  be_n;
    logic [31:0] wdata, rdata, q;
    logic [1:0]  tmode;
    logic [2:0]  bytex;
    logic [9:0]  arb;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          cyc       = 0;
    int          n;
    logic [2:0]  bytex_tab [4] = '{3'h7, 3'h2, 3'h4, 3'h1};

    // Clock of 20 ns period.
    always #10 clk_sys = ~clk_sys;

    bdp_regs #(.CHIP_RST_CYCLES(16'h0004)) bdp_regs_i
    (
        .CLK_SYS(clk_sys), .RESET(reset), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(addr),
        .PRIMARY_COMMAND_BYTE_ENABLES_N(be_n), .CFG_WDATA(wdata), .BRIDGE_SEC_RESET_BIT(sec_bit),
        .CACHE_LINE_SIZE(cls), .PRI_POSTED_WRITE(pw), .CFG_RDATA(rdata), .CFG_ACK(ack),
        .CHIP_RESET(chip_rst), .SEC_BUS_RESET(sec_rst), .BRIDGE_SEC_RESET_SET(sec_set),
        .CNT_TEST_MODE(tmode), .CNT_BYTE_EXERCISE(bytex), .ARB_HIGH_PRIO(arb),
        .DS_PREFETCH_DW(ds_dw), .US_PREFETCH_DW(us_dw), .NP_FLUSH_EN(fl_en), .NP_FLUSH_PULSE(fl_pulse)
    );

    bdp_host_model bdp_host_model_i
    (
        .clk(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(addr), .be_n(be_n),
        .wdata(wdata), .rdata(rdata), .ack(ack)
    );

    // Compares one value with case equality and counts the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc >= 5000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // Main sequence of tests.
    initial
    begin
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        bdp_host_model_i.cfg_read(8'h40, q);
        chk(q, 32'h02000000, "reset 0x40");
        bdp_host_model_i.cfg_read(8'h44, q);
        chk(q, 32'h00000006, "reset 0x44");
        chk(bytex, 32'h7, "reset bytes");
        chk(ds_dw, 32'h10, "ds line default");
        chk(us_dw, 32'h10, "us line default");
        bdp_host_model_i.cfg_read(8'h48, q);
        chk(q, 32'h0, "unmapped");
        $display("test reset values done");

        for (int t = 0; t < 4; t++)
        begin
            bdp_host_model_i.cfg_write(8'h40, 4'hD, 32'h0000F800 | (t << 9));
            chk(tmode, t, "test mode");
            chk(bytex, bytex_tab[t], "byte exercise");
            chk(chip_rst, 32'h0, "zero to reset bit");
            bdp_host_model_i.cfg_read(8'h40, q);
            chk(q, 32'h02000000 | (t << 9), "test readback");
        end
        $display("test counter modes done");

        bdp_host_model_i.cfg_write(8'h40, 4'h3, 32'hFFFF0000);
        chk(arb, 32'h3FF, "arb all high");
        bdp_host_model_i.cfg_read(8'h40, q);
        chk(q, 32'h03FF0600, "arb readback");
        bdp_host_model_i.cfg_write(8'h40, 4'hB, 32'h00AA0000);
        chk(arb, 32'h3AA, "arb low lane only");
        $display("test arbiter done");

        for (int c = 0; c < 4; c++)
        begin
            bdp_host_model_i.cfg_write(8'h44, 4'hE, (c << 6) | ((3 - c) << 4) | 8);
            @(negedge clk_sys);
            chk(ds_dw, (c + 1) * 16, "ds count");
            chk(us_dw, (4 - c) * 16, "us count");
            bdp_host_model_i.cfg_read(8'h44, q);
            chk(q, (c << 6) | ((3 - c) << 4), "rd ctl readback");
        end
        bdp_host_model_i.cfg_write(8'h44, 4'hE, 32'h00000006);
        cls = 8'h20;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk(ds_dw, 32'h20, "ds line size");
        chk(us_dw, 32'h20, "us line size");
        cls = 8'h00;
        $display("test prefetch done");

        pw = 1'b1;
        @(negedge clk_sys);
        pw = 1'b0;
        chk(fl_pulse, 32'h0, "no flush when clear");
        bdp_host_model_i.cfg_write(8'h44, 4'hE, 32'h00000007);
        chk(fl_en, 32'h1, "flush enable");
        pw = 1'b1;
        @(negedge clk_sys);
        pw = 1'b0;
        chk(fl_pulse, 32'h1, "flush pulse");
        @(negedge clk_sys);
        chk(fl_pulse, 32'h0, "flush pulse ends");
        $display("test flush done");

        bdp_host_model_i.cfg_write(8'h40, 4'hD, 32'h00000100);
        chk(chip_rst, 32'h1, "chip reset starts");
        chk(sec_rst, 32'h1, "secondary reset");
        chk(sec_set, 32'h1, "bridge bit set");
        sec_bit = 1'b1;
        bdp_host_model_i.cfg_write(8'h40, 4'h3, 32'h00000000);
        chk(arb, 32'h3AA, "write refused in chip reset");
        n = 0;
        while (chip_rst === 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(chip_rst, 32'h0, "chip reset ends");
        chk(n, 32'h4, "chip reset length");
        chk(sec_set, 32'h0, "bridge bit request ends");
        bdp_host_model_i.cfg_read(8'h40, q);
        chk(q, 32'h02000000, "0x40 restored");
        bdp_host_model_i.cfg_read(8'h44, q);
        chk(q, 32'h00000006, "0x44 restored");
        chk(sec_rst, 32'h1, "secondary reset held");
        sec_bit = 1'b0;
        @(negedge clk_sys);
        @(negedge clk_sys);
        chk(sec_rst, 32'h0, "secondary reset released");
        $display("test chip reset done");
        tally_and_finish();
    end
endmodule
